// *** core/adc_pkg.sv ***
// Shared constants and types for the converter control block
package adc_pkg;
    // Printed register indices; the byte address is four times each
    localparam logic [7:0] AUX_IDX = 8'h9c;
    localparam logic [7:0] MAIN_IDX = 8'h9d;
    localparam logic [7:0] RES_HIGH_IDX = 8'h9e;
    localparam logic [7:0] RES_LOW_IDX = 8'h9f;
    localparam logic [31:0] AUX_ADDR = {22'h0, AUX_IDX, 2'h0};
    localparam logic [31:0] MAIN_ADDR = {22'h0, MAIN_IDX, 2'h0};
    localparam logic [31:0] RES_HIGH_ADDR = {22'h0, RES_HIGH_IDX, 2'h0};
    localparam logic [31:0] RES_LOW_ADDR = {22'h0, RES_LOW_IDX, 2'h0};

    // Main control field positions
    localparam int MAIN_EN_BIT = 0;
    localparam int MAIN_GO_BIT = 1;
    localparam int MAIN_CHS_LSB = 2;
    localparam int MAIN_CS_LSB = 6;
    // Auxiliary control field positions
    localparam int AUX_LEVEL_BIT = 0;
    localparam int AUX_REFEN_BIT = 2;
    localparam int AUX_CHANNEL_SELECT_MSB_BIT = 6;
    localparam int AUX_ALIGN_BIT = 7;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // Conversion clock dividers, in system clocks per conversion clock
    localparam logic [7:0] DIV_CODE0 = 8'h08;
    localparam logic [7:0] DIV_CODE1 = 8'h10;
    localparam logic [7:0] DIV_CODE2 = 8'h20;
    localparam logic [7:0] DIV_CODE3 = 8'h80;
    // Conversion clock periods per conversion (49) and after an abort (2)
    localparam logic [5:0] TAD_PER_CONV = 6'h31;
    localparam logic [5:0] HOLDOFF_TAD = 6'h02;

    // Channel codes
    localparam logic [4:0] FIXED_REF_CODE = 5'h12;
    localparam int NUM_INPUTS = 17;

    // AHB transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_CONV = 3'h2,
        S_HOLD = 3'h4
    } seq_state_t;
endpackage

// *** core/adc_conv_sequencer.sv ***
// Conversion clock divider and conversion timing sequencer
`timescale 1ns/1ps
module adc_conv_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic request,
    input wire logic [1:0] clock_select,
    output logic conv_tick,
    output logic active,
    output logic done
);
    // All sequencer state in one record
    typedef struct packed {
        adc_pkg::seq_state_t state;
        logic [6:0] presc;
        logic [5:0] conv_clock_period;
        logic tick;
        logic active;
        logic done;
    } seq_t;

    seq_t q;
    seq_t next_q;
    logic [6:0] term;

    // Last prescaler count for the selected divider
    // (R1) divider code decode
    always_comb begin
        case (clock_select)
            2'h0: term = 7'(adc_pkg::DIV_CODE0 - 8'h01);
            2'h1: term = 7'(adc_pkg::DIV_CODE1 - 8'h01);
            2'h2: term = 7'(adc_pkg::DIV_CODE2 - 8'h01);
            default: term = 7'(adc_pkg::DIV_CODE3 - 8'h01);
        endcase
    end

    // Next state of the sequencer
    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        next_q.done = 1'b0;
        case (q.state)
            adc_pkg::S_IDLE: begin
                // Done pulse still pending: request not yet dropped
                if (enable && request && !q.done) begin
                    next_q.state = adc_pkg::S_CONV;
                    next_q.presc = 7'h00;
                    next_q.conv_clock_period = 6'h00;
                end
            end
            adc_pkg::S_CONV: begin
                if (!enable || !request) begin
                    // (R15) abort starts the holdoff
                    next_q.state = adc_pkg::S_HOLD;
                    next_q.presc = 7'h00;
                    next_q.conv_clock_period = 6'h00;
                end else if (q.presc >= term) begin
                    // Greater-or-equal survives a divider change mid-run
                    next_q.presc = 7'h00;
                    next_q.tick = 1'b1;
                    // (R13) end after 49 periods
                    if (q.conv_clock_period == adc_pkg::TAD_PER_CONV - 6'h01) begin
                        next_q.done = 1'b1;
                        next_q.state = adc_pkg::S_IDLE;
                    end else begin
                        next_q.conv_clock_period = q.conv_clock_period + 6'h01;
                    end
                end else begin
                    next_q.presc = q.presc + 7'h01;
                end
            end
            adc_pkg::S_HOLD: begin
                if (q.presc >= term) begin
                    next_q.presc = 7'h00;
                    next_q.tick = 1'b1;
                    // (R15) two periods before next acquisition
                    if (q.conv_clock_period == adc_pkg::HOLDOFF_TAD - 6'h01) begin
                        next_q.state = adc_pkg::S_IDLE;
                    end else begin
                        next_q.conv_clock_period = q.conv_clock_period + 6'h01;
                    end
                end else begin
                    next_q.presc = q.presc + 7'h01;
                end
            end
            default: begin
                next_q.state = adc_pkg::S_IDLE;
            end
        endcase
        next_q.active = (next_q.state == adc_pkg::S_CONV);
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{state: adc_pkg::S_IDLE, presc: 7'h00, conv_clock_period: 6'h00, tick: 1'b0, active: 1'b0, done: 1'b0};
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign conv_tick = q.tick;
    assign active = q.active;
    assign done = q.done;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_tick_spacing_div8: assert property ((ce && q.tick && q.active && enable && request && clock_select == 2'h0
        && q.state == adc_pkg::S_CONV) |=> !q.tick [*7]) else $error("tick spacing wrong at divide by 8"); // R1
    a_abort_holdoff: assert property ((ce && q.state == adc_pkg::S_CONV && (!enable || !request))
        |=> !q.active [*8]) else $error("conversion restarted inside holdoff"); // R15
    a_done_count: assert property ($rose(q.done) |-> $past(q.conv_clock_period) == adc_pkg::TAD_PER_CONV - 6'h01)
        else $error("conversion ended at wrong period count"); // R13
endmodule

// *** core/adc_control_registers.sv ***
// Converter control registers with AHB-Lite slave and result formatting
// Function
// (R1) Divider codes give Fsys/8, /16, /32, /128
// (R2) Five-bit channel split over two registers
// (R3) Codes 0..16 route matching analog input
// (R4) Code 10010 routes internal reference; others reserved
// (R5) Writing go starts; hardware clears at end
// (R6) Go reads 1 only while converting; the code reads the go register, also 1 while a restart waits out the holdoff
// (R7) Main bit 0 enables the converter
// (R8) Aux bit 7 selects right alignment
// (R9) Aux bit 2 selects internal reference
// (R10) Aux bit 0 picks 2.0V or 2.4V
// (R11) Left alignment layout of result bytes
// (R12) Right alignment keeps upper ten bits
// (R13) Conversion lasts 49 conversion clock periods
// (R14) Completion clears go, flags, loads result
// (R15) Abort keeps result, two-period holdoff follows
// (R16) Enable and go need separate writes
// (R17) Go ignored while converter disabled
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module adc_control_registers (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog core side
    input wire logic [11:0] conversion_result,
    output logic converter_enable,
    output logic [4:0] channel_select,
    output logic [16:0] input_route,
    output logic fixed_ref_route,
    output logic internal_ref_enable,
    output logic internal_ref_level,
    output logic conv_clock_tick,
    output logic conversion_active,
    output logic conversion_done_flag_set
);
    // All register state in one record
    typedef struct packed {
        logic [1:0] conv_clock_select; // Divider code
        logic [3:0] channel_low; // Channel bits 3..0
        logic go; // Go/done
        logic enable; // Converter on
        logic result_align_select; // 1 = right aligned
        logic channel_select_msb; // Channel bit 4
        logic internal_ref_enable; // Reference from regulator
        logic internal_ref_level; // 1 = 2.0V, 0 = 2.4V
        logic [7:0] result_high; // Formatted result, high byte
        logic [7:0] result_low; // Formatted result, low byte
        logic wr_pend; // Write data phase pending
        logic [1:0] wr_sel; // Which register the write targets
        logic wr_hit; // Write address was a writable control register
        logic [31:0] rdata; // Read data for the data phase
        logic ready; // Bus ready
        logic [16:0] route; // One-hot input routing
        logic fixed_route; // Internal reference routing
        logic done_flag; // One-cycle completion flag pulse
    } regs_t;

    regs_t q;
    regs_t next_q;
    logic seq_done;
    logic seq_tick;
    logic seq_active;
    logic addr_valid;
    logic [4:0] next_channel;
    logic [16:0] next_route; // Decoded routing for the next channel code
    logic [7:0] main_value;
    logic [7:0] aux_value;

    // Timing of conversions and holdoff
    adc_conv_sequencer u_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .enable(q.enable),
        .request(q.go),
        .clock_select(q.conv_clock_select),
        .conv_tick(seq_tick),
        .active(seq_active),
        .done(seq_done)
    );

    // Address phase accepted when selected, ready, and NONSEQ or SEQ
    assign addr_valid = hsel && hready && (htrans == adc_pkg::HTRANS_NONSEQ || htrans == adc_pkg::HTRANS_SEQ);

    // Readback images of the two control registers
    always_comb begin
        main_value = adc_pkg::CTRL_RESET;
        main_value[adc_pkg::MAIN_CS_LSB +: 2] = q.conv_clock_select;
        // (R2) low channel bits in main register
        main_value[adc_pkg::MAIN_CHS_LSB +: 4] = q.channel_low;
        // (R6) go reads the go register bit, not the sequencer active state
        main_value[adc_pkg::MAIN_GO_BIT] = q.go;
        main_value[adc_pkg::MAIN_EN_BIT] = q.enable;
        // Unused bits read as zero
        aux_value = adc_pkg::CTRL_RESET;
        aux_value[adc_pkg::AUX_ALIGN_BIT] = q.result_align_select;
        // (R2) top channel bit in aux register
        aux_value[adc_pkg::AUX_CHANNEL_SELECT_MSB_BIT] = q.channel_select_msb;
        aux_value[adc_pkg::AUX_REFEN_BIT] = q.internal_ref_enable;
        aux_value[adc_pkg::AUX_LEVEL_BIT] = q.internal_ref_level;
    end

    // Next state of registers, bus and routing
    always_comb begin
        next_q = q;
        next_q.ready = 1'b1;
        next_q.done_flag = 1'b0;

        // Completion: clear go, raise flag, load result
        if (seq_done) begin
            // (R14) completion actions
            next_q.go = 1'b0;
            next_q.done_flag = 1'b1;
            if (q.result_align_select) begin
                // (R12) right alignment, lowest two bits dropped
                next_q.result_high = {6'h00, conversion_result[11:10]};
                next_q.result_low = conversion_result[9:2];
            end else begin
                // (R11) left alignment, low nibble unused
                next_q.result_high = conversion_result[11:4];
                next_q.result_low = {conversion_result[3:0], 4'h0};
            end
        end

        // Data phase of a write; comes after completion so a set wins
        if (q.wr_pend && q.wr_hit) begin
            if (q.wr_sel == 2'h1) begin
                next_q.conv_clock_select = hwdata[adc_pkg::MAIN_CS_LSB +: 2];
                next_q.channel_low = hwdata[adc_pkg::MAIN_CHS_LSB +: 4];
                // (R7) enable bit
                next_q.enable = hwdata[adc_pkg::MAIN_EN_BIT];
                // (R16) go needs enable already set
                // (R17) go refused while disabled
                // (R5) software start or abort
                next_q.go = hwdata[adc_pkg::MAIN_GO_BIT] && q.enable && hwdata[adc_pkg::MAIN_EN_BIT];
            end else if (q.wr_sel == 2'h0) begin
                // (R8) alignment select
                next_q.result_align_select = hwdata[adc_pkg::AUX_ALIGN_BIT];
                next_q.channel_select_msb = hwdata[adc_pkg::AUX_CHANNEL_SELECT_MSB_BIT];
                // (R9) reference source
                next_q.internal_ref_enable = hwdata[adc_pkg::AUX_REFEN_BIT];
                // (R10) regulator level
                next_q.internal_ref_level = hwdata[adc_pkg::AUX_LEVEL_BIT];
            end
        end
        // Result registers are read only; writes there are dropped

        // Address phase: capture write target, answer reads at once
        next_q.wr_pend = addr_valid && hwrite;
        next_q.wr_hit = 1'b0;
        next_q.wr_sel = q.wr_sel;
        if (addr_valid) begin
            next_q.rdata = 32'h0000_0000;
            if (haddr == adc_pkg::AUX_ADDR) begin
                next_q.wr_hit = 1'b1;
                next_q.wr_sel = 2'h0;
                next_q.rdata = {24'h000000, aux_value};
            end else if (haddr == adc_pkg::MAIN_ADDR) begin
                next_q.wr_hit = 1'b1;
                next_q.wr_sel = 2'h1;
                next_q.rdata = {24'h000000, main_value};
            end else if (haddr == adc_pkg::RES_HIGH_ADDR) begin
                next_q.rdata = {24'h000000, q.result_high};
            end else if (haddr == adc_pkg::RES_LOW_ADDR) begin
                next_q.rdata = {24'h000000, q.result_low};
            end
            // Unmapped address: read zero, write ignored, still OKAY
        end

        // Channel routing from the committed five-bit code
        next_channel = {next_q.channel_select_msb, next_q.channel_low};
        // (R4) internal reference code
        next_q.fixed_route = (next_channel == adc_pkg::FIXED_REF_CODE);
        // Per-input decode comes from the loop below, one driver for the record
        next_q.route = next_route;
    end

    // (R3) one route per analog input
    genvar gi;
    generate
        for (gi = 0; gi < adc_pkg::NUM_INPUTS; gi = gi + 1) begin : g_route
            assign next_route[gi] = (next_channel == 5'(gi));
        end
    endgenerate

    // Register update; everything freezes while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ready <= 1'b1;
            q.route <= 17'h00001;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = 1'b0 & q.ready;
    assign converter_enable = q.enable;
    assign channel_select = {q.channel_select_msb, q.channel_low};
    assign input_route = q.route;
    assign fixed_ref_route = q.fixed_route;
    assign internal_ref_enable = q.internal_ref_enable;
    assign internal_ref_level = q.internal_ref_level;
    assign conv_clock_tick = seq_tick;
    assign conversion_active = seq_active;
    assign conversion_done_flag_set = q.done_flag;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_go_needs_enable: assert property (q.go |-> q.enable) // R17
        else $error("go set while converter disabled");
    a_same_write_no_start: assert property ((ce && q.wr_pend && q.wr_hit && q.wr_sel == 2'h1 && !q.enable && !seq_done)
        |=> !q.go) else $error("go set in the enabling write"); // R16
    a_done_clears_go: assert property ((ce && seq_done && !(q.wr_pend && q.wr_hit)) |=> !q.go && q.done_flag)
        else $error("completion did not clear go or flag"); // R14
    a_left_layout: assert property ((ce && seq_done && !q.result_align_select) |=> q.result_high
        == $past(conversion_result[11:4]) && q.result_low == {$past(conversion_result[3:0]), 4'h0})
        else $error("left aligned result wrong"); // R11
    a_right_layout: assert property ((ce && seq_done && q.result_align_select) |=> q.result_high
        == {6'h00, $past(conversion_result[11:10])} && q.result_low == $past(conversion_result[9:2]))
        else $error("right aligned result wrong"); // R12
    a_result_kept: assert property (!seq_done |=> $stable(q.result_high) && $stable(q.result_low))
        else $error("result changed without completion"); // R15
    a_active_with_go: assert property ($rose(seq_active) |-> q.go) // R6
        else $error("conversion running without go");
    a_fixed_route: assert property (q.fixed_route |-> channel_select == adc_pkg::FIXED_REF_CODE && q.route == 17'h0)
        else $error("internal reference routing wrong"); // R4
    a_input_route: assert property ($onehot0(q.route) && (channel_select > 5'h10 || q.route[channel_select])) // R3
        else $error("input routing wrong");

    c_conv_done: cover property (seq_done);
    c_abort: cover property ($fell(seq_active) && !seq_done);
    c_right_done: cover property (seq_done && q.result_align_select);
endmodule

// *** bench/adc_core_model.sv ***
// Behavioural model of the analog sample-and-hold and converter core
`timescale 1ns/1ps
module adc_core_model #(
    parameter logic [11:0] FIXED_REF_LEVEL = 12'h4d2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conversion_active,
    input wire logic [16:0] input_route,
    input wire logic fixed_ref_route,
    input wire logic [11:0] analog_level,
    output logic [11:0] conversion_result
);
    logic [11:0] routed; // Value on the selected input
    logic [11:0] held; // Sample held for the running conversion
    logic was_active; // Start detector
    // Each input reads the test level plus its own index, so a wrong route shows
    // input and reference routing
    always_comb begin
        routed = ~analog_level;
        for (int i = 0; i < 17; i++) begin
            if (input_route[i]) begin
                routed = analog_level + 12'(i);
            end
        end
        if (fixed_ref_route) begin
            routed = FIXED_REF_LEVEL;
        end
    end
    // Sample at start; when idle the output toggles so stale data never matches
    // result stands while converting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held <= 12'h000;
            was_active <= 1'b0;
        end else begin
            was_active <= conversion_active;
            if (conversion_active && !was_active) begin
                held <= routed;
            end else if (!conversion_active) begin
                held <= ~held;
            end
        end
    end
    assign conversion_result = held;
endmodule

// *** bench/adc_control_registers_tb_top.sv ***
// Self-checking testbench for the converter control registers
`timescale 1ns/1ps
module adc_control_registers_tb_top;
    localparam logic [11:0] FIXED_LEVEL = 12'h4d2; // Reference reading of the model
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, converter_enable, fixed_ref_route;
    logic internal_ref_enable, internal_ref_level, conv_clock_tick, conversion_active, done;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] conversion_result, analog_level, expr;
    logic [4:0] channel_select, ch;
    logic [16:0] input_route;
    logic [7:0] v;
    logic al;
    int failures, tests_run, cycles, seed, div, ticks, bad, n, done_count;

    adc_control_registers uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conversion_result(conversion_result),
        .converter_enable(converter_enable), .channel_select(channel_select), .input_route(input_route),
        .fixed_ref_route(fixed_ref_route), .internal_ref_enable(internal_ref_enable),
        .internal_ref_level(internal_ref_level), .conv_clock_tick(conv_clock_tick),
        .conversion_active(conversion_active), .conversion_done_flag_set(done));
    adc_core_model #(.FIXED_REF_LEVEL(FIXED_LEVEL)) core (.hclk(hclk), .hresetn(hresetn),
        .conversion_active(conversion_active), .input_route(input_route), .fixed_ref_route(fixed_ref_route),
        .analog_level(analog_level), .conversion_result(conversion_result));

    // Free-running bus clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Hang guard and completion counter
    always @(posedge hclk) begin
        cycles++;
        if (done === 1'b1) done_count++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Single compare for every kind of value
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One AHB-Lite single transfer; waits on hready in both phases
    task bus(input logic [31:0] a, input logic w, input logic [7:0] wd);
        hsel <= 1'b1; haddr <= a; htrans <= adc_pkg::HTRANS_NONSEQ; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask
    // Expected result bytes for either alignment
    function automatic logic [7:0] exp_hi(logic [11:0] r, logic a);
        return a ? {6'h00, r[11:10]} : r[11:4];
    endfunction
    function automatic logic [7:0] exp_lo(logic [11:0] r, logic a);
        return a ? r[9:2] : {r[3:0], 4'h0};
    endfunction
    // Counts conversion clock ticks until completion, checking their spacing
    task wait_done();
        int gap;
        ticks = 0; bad = 0; gap = 0; n = 0;
        while (done !== 1'b1 && n < 8000) begin
            @(posedge hclk);
            #1;
            n++;
            gap++;
            // The last tick comes with active already low, so active is not required
            if (conv_clock_tick === 1'b1) begin
                ticks++;
                if (ticks > 1 && gap != div) bad++;
                gap = 0;
            end
        end
    endtask
    // Configure, start one conversion and check the loaded result
    task convert(input logic [1:0] cs);
        div = (cs == 2'h0) ? 8 : (cs == 2'h1) ? 16 : (cs == 2'h2) ? 32 : 128;
        bus(adc_pkg::AUX_ADDR, 1'b1, {al, ch[4], 6'h00});
        bus(adc_pkg::MAIN_ADDR, 1'b1, {cs, ch[3:0], 2'h1});
        bus(adc_pkg::MAIN_ADDR, 1'b1, {cs, ch[3:0], 2'h3});
        bus(adc_pkg::MAIN_ADDR, 1'b0, 8'h00);
        check("go while busy", 32'h1, {31'h0, rd[1]});
        wait_done();
        check("tick count", 32'h31, ticks);
        check("tick spacing", 32'h0, bad);
        bus(adc_pkg::MAIN_ADDR, 1'b0, 8'h00);
        check("main after done", {24'h0, cs, ch[3:0], 2'h1}, rd);
        expr = (ch == adc_pkg::FIXED_REF_CODE) ? FIXED_LEVEL : analog_level + 12'(ch);
        bus(adc_pkg::RES_HIGH_ADDR, 1'b0, 8'h00);
        check("result high", {24'h0, exp_hi(expr, al)}, rd);
        bus(adc_pkg::RES_LOW_ADDR, 1'b0, 8'h00);
        check("result low", {24'h0, exp_lo(expr, al)}, rd);
    endtask

    initial begin
        seed = 32'h909b;
        hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; analog_level = 12'h000; al = 1'b0; ch = 5'h00;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, read-only results and an unmapped word
        for (int i = 0; i < 5; i++) begin
            bus(adc_pkg::AUX_ADDR + 32'(4 * i), 1'b0, 8'h00);
            check("reset read", 32'h0, rd);
        end
        bus(adc_pkg::RES_HIGH_ADDR, 1'b1, 8'hff);
        bus(adc_pkg::RES_HIGH_ADDR, 1'b0, 8'h00);
        check("result read only", 32'h0, rd);
        // Every channel code up to the reference, routing outputs
        for (int c = 0; c < 19; c++) begin
            bus(adc_pkg::AUX_ADDR, 1'b1, {1'b0, c[4], 6'h00});
            bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, c[3:0], 2'h0});
            // Let the write's edge settle before looking at the outputs
            @(posedge hclk);
            check("channel", 32'(c), {27'h0, channel_select});
            check("route", (c < 17) ? 32'h1 << c : 32'h0, {15'h0, input_route});
            check("ref route", (c == 18) ? 32'h1 : 32'h0, {31'h0, fixed_ref_route});
        end
        // Clock enable low: the bus still answers but no register moves
        ce <= 1'b0;
        bus(adc_pkg::MAIN_ADDR, 1'b1, 8'h00);
        ce <= 1'b1;
        @(posedge hclk);
        check("frozen channel", 32'h12, {27'h0, channel_select});
        // Random auxiliary settings and their outputs
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            bus(adc_pkg::AUX_ADDR, 1'b1, v);
            bus(adc_pkg::AUX_ADDR, 1'b0, 8'h00);
            check("aux readback", {24'h0, v & 8'hc5}, rd);
            check("ref enable", {31'h0, v[2]}, {31'h0, internal_ref_enable});
            check("ref level", {31'h0, v[0]}, {31'h0, internal_ref_level});
        end
        // Go refused while disabled, and when set together with enable
        bus(adc_pkg::MAIN_ADDR, 1'b1, 8'h02);
        bus(adc_pkg::MAIN_ADDR, 1'b0, 8'h00);
        check("go disabled", 32'h0, rd);
        bus(adc_pkg::MAIN_ADDR, 1'b1, 8'h03);
        bus(adc_pkg::MAIN_ADDR, 1'b0, 8'h00);
        check("go with enable", 32'h1, rd);
        check("enable out", 32'h1, {31'h0, converter_enable});
        check("no start", 32'h0, {31'h0, conversion_active});
        // One conversion per clock divider, random input (internal reference on the last), alignment and level
        for (int cs = 0; cs < 4; cs++) begin
            analog_level <= 12'($random(seed));
            al = 1'($random(seed));
            ch = (cs == 3) ? adc_pkg::FIXED_REF_CODE : 5'({$random(seed)} % 17);
            convert(2'(cs));
        end
        // Abort mid-run keeps results and gives no completion pulse
        check("done pulses", 32'h4, 32'(done_count));
        n = done_count;
        bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, ch[3:0], 2'h3});
        repeat (100) @(posedge hclk);
        bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, ch[3:0], 2'h1});
        repeat (900) @(posedge hclk);
        check("done after abort", 32'(n), 32'(done_count));
        bus(adc_pkg::RES_LOW_ADDR, 1'b0, 8'h00);
        check("result kept", {24'h0, exp_lo(expr, al)}, rd);
        // Abort a running conversion and ask at once for a restart
        bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, ch[3:0], 2'h3});
        repeat (20) @(posedge hclk);
        bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, ch[3:0], 2'h1});
        bus(adc_pkg::MAIN_ADDR, 1'b1, {2'h0, ch[3:0], 2'h3});
        n = 0;
        while (conversion_active !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        // Restart must wait two periods at divide by 8, and must come at all
        check("holdoff", 32'h1, 32'(n >= int'(adc_pkg::HOLDOFF_TAD) * int'(adc_pkg::DIV_CODE0) && n < 40));
        give_verdict();
    end
endmodule
